/* File: bss_pkg.sv */
// Package with constants and carrier types of the boot strap sampler
package bss_pkg;

  // Pin counts of the strap buses
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;

  // Wishbone register byte offsets
  localparam logic [4:0] OFS_CHIP   = 5'h00;  // chip_config_reg, read only
  localparam logic [4:0] OFS_PIN    = 5'h04;  // pin_config_reg, read/write
  localparam logic [4:0] OFS_CLK    = 5'h08;  // Clock divider fields, read only
  localparam logic [4:0] OFS_STAT   = 5'h0c;  // Capture status, read only
  localparam logic [4:0] OFS_RAWA   = 5'h10;  // Synchronised address straps
  localparam logic [4:0] OFS_RAWD   = 5'h14;  // Synchronised data straps

  // Strap pin positions on the address bus
  localparam int A_PCI_ROLE = 19;
  localparam int A_SHARED1  = 18;
  localparam int A_SYS_HI   = 14;
  localparam int A_SYS_LO   = 13;
  localparam int A_ENDIAN   = 12;
  localparam int A_PCI_HI   = 11;
  localparam int A_PCI_LO   = 10;
  localparam int A_SHARED2  = 9;
  localparam int A_BOOT_HI  = 8;
  localparam int A_BOOT_LO  = 6;
  localparam int A_CORE_HI  = 3;

  // Strap pin positions on the data bus
  localparam int D_BOARD_LO = 8;
  localparam int D_TIMER    = 7;
  localparam int D_SHARED3  = 6;
  localparam int D_BYTE_EN  = 5;
  localparam int D_ACK_SRC  = 4;
  localparam int D_SHARED4  = 3;
  localparam int D_ARB      = 2;
  localparam int D_WIDTH_HI = 1;

  // Cycles after main reset release until the synchroniser holds pin levels
  localparam logic [1:0] SETTLE_CYCLES = 2'h2;

  // Divider bases
  localparam logic [3:0] PCI_DIV_BASE = 4'h8;  // LL gives 8, HH gives 11
  localparam logic [2:0] SYS_DIV_BASE = 3'h4;  // LL gives 4, HH gives 1

  // Fields loaded at main reset release
  typedef struct packed {
    logic [7:0] board_info;        // Board information
    logic       timer_int_en;      // Core timer interrupt control
    logic       byte_enable_n_sel; // Byte enable or byte write enable at boot
    logic       ack_source;        // Internal or external boot acknowledge
    logic [1:0] boot_bus_width;    // Boot device data width
    logic       arb_select;        // Internal or external PCI arbiter
    logic [2:0] boot_dev_clk;      // Boot device and its clock divide
    logic [3:0] core_clock_ratio;  // Core clock to master clock ratio
    logic       endian_big;        // 1 big endian, 0 little endian
    logic       pci_role_select;   // 1 host, 0 satellite
  } bss_boot_s;

  // Shared pin group selects
  typedef struct packed {
    logic sel_d3;                  // Group selected by data bit 3
    logic sel_d6;                  // Group selected by data bit 6
    logic sel_a9;                  // Group selected by address bit 9
    logic shared_pin_group_select; // 1 check_bit_lines, 0 general_purpose_io
  } bss_pins_s;

  // Fields loaded at clock-generator reset release
  typedef struct packed {
    logic [3:0] pci_div;       // pci_bus_clock divide of core_clock
    logic [2:0] sys_div;       // external_system_clock divide of internal_bus_clock
    logic [1:0] pci_div_code;  // Raw strap pattern
    logic [1:0] sys_div_code;  // Raw strap pattern
  } bss_clk_s;

endpackage

/* File: bss_sync.sv */
// Two-stage synchroniser for strap and reset pins
`timescale 1ns/1ps
module bss_sync #(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '1
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_arst_n,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] stage1;  // Only read by the second stage

  // Two flops, reset to the pull-up level
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stage1 <= RST;
      o_q    <= RST;
    end else begin
      stage1 <= i_d;
      o_q    <= stage1;
    end
  end

endmodule

/* File: bss_top.sv */
// Boot strap sampler: captures strap pins into configuration fields
//
// Contract
// - Reset release samples straps into config
// - High pin stores one, low stores zero
// - Undriven strap reads one via pull-up
// - Address 19 selects PCI host or satellite
// - Address 18 selects GPIO or check bits
// - Address 17..15 reserved, no function
// - Address 11..10 set PCI clock divide
// - Data 2 selects PCI arbiter
// - Address 14..13 set system clock divide
// - Address 8..6 choose boot device, clock
// - Data 5 selects byte enable function
// - Data 4 selects boot acknowledge source
// - Data 1..0 set boot bus width
// - Address 3..0 set core clock ratio
// - Four straps select shared pin groups
// - Data 7 controls core timer interrupt
// - System divide 4,3,2,1 at clock reset
// - PCI divide 8..11 at clock reset
// - Address 12 selects byte order
`timescale 1ns/1ps
module bss_top (
  input  wire logic                       i_ref_clk,
  input  wire logic                       i_arst_n,
  input  wire logic                       i_clock_generator_reset_n,
  input  wire logic [bss_pkg::ADDR_W-1:0] i_addr_pins,
  input  wire logic [bss_pkg::DATA_W-1:0] i_data_pins,
  input  wire logic                       i_wb_cyc,
  input  wire logic                       i_wb_stb,
  input  wire logic                       i_wb_we,
  input  wire logic [4:0]                 i_wb_adr,
  input  wire logic [3:0]                 i_wb_sel,
  input  wire logic [31:0]                i_wb_dat,
  output logic      [31:0]                o_wb_dat,
  output logic                            o_wb_ack,
  output bss_pkg::bss_boot_s              o_boot_cfg,
  output bss_pkg::bss_pins_s              o_pin_cfg,
  output bss_pkg::bss_clk_s               o_clk_cfg,
  output logic                            o_main_done,
  output logic                            o_cg_done
);

  localparam int SW = bss_pkg::ADDR_W + bss_pkg::DATA_W + 1;

  // Synchronised pins
  logic [SW-1:0]                sync_q;     // Second stage of the synchroniser
  logic [bss_pkg::ADDR_W-1:0]   addr_s;     // Address straps
  logic [bss_pkg::DATA_W-1:0]   data_s;     // Data straps
  logic                         cg_n_s;     // Clock-generator reset level
  logic                         cg_n_q;     // Previous level for edge detection
  logic                         cg_rise;    // Clock-generator reset release
  logic [1:0]                   settle;     // Cycles since main reset release
  logic                         main_cap;   // One-cycle capture strobe
  logic                         wb_req;     // New Wishbone access
  logic                         pin_wr;     // Software write to pin_config_reg
  logic [31:0]                  next_rdat;  // Read data mux

  // Divider decode: base plus or minus the two-bit strap pattern
  function automatic logic [3:0] bss_div(input logic [3:0] base, input logic [1:0] code,
                                         input logic down);
    bss_div = down ? base - {2'h0, code} : base + {2'h0, code};
  endfunction

  // Pins pass two flops; pull-ups make the idle value all ones
  bss_sync #(
    .W   (SW),
    .RST ({SW{1'b1}})
  ) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_arst_n  (i_arst_n),
    .i_d       ({i_clock_generator_reset_n, i_addr_pins, i_data_pins}),
    .o_q       (sync_q)
  );

  assign cg_n_s  = sync_q[SW-1];
  assign addr_s  = sync_q[SW-2 -: bss_pkg::ADDR_W];
  assign data_s  = sync_q[bss_pkg::DATA_W-1:0];
  assign cg_rise = cg_n_s && !cg_n_q;
  assign main_cap = !o_main_done && (settle == bss_pkg::SETTLE_CYCLES);
  assign wb_req  = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign pin_wr  = wb_req && i_wb_we && i_wb_sel[0] && (i_wb_adr == bss_pkg::OFS_PIN);

  // Edge detector on the synchronised clock-generator reset
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cg_n_q <= 1'b1;
    end else begin
      cg_n_q <= cg_n_s;
    end
  end

  // Settle counter: waits until the synchroniser holds post-release levels
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      settle      <= 2'h0;
      o_main_done <= 1'b0;
    end else if (!o_main_done) begin
      settle <= settle + 2'h1;
      if (main_cap) begin
        o_main_done <= 1'b1;
      end
    end
  end

  // Main-reset fields; levels stored as read, one for high
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_boot_cfg <= '1;
    end else if (main_cap) begin
      o_boot_cfg.pci_role_select   <= addr_s[bss_pkg::A_PCI_ROLE];
      o_boot_cfg.endian_big        <= addr_s[bss_pkg::A_ENDIAN];
      o_boot_cfg.boot_dev_clk      <= addr_s[bss_pkg::A_BOOT_HI:bss_pkg::A_BOOT_LO];
      o_boot_cfg.core_clock_ratio  <= addr_s[bss_pkg::A_CORE_HI:0];
      o_boot_cfg.board_info        <= data_s[bss_pkg::DATA_W-1:bss_pkg::D_BOARD_LO];
      o_boot_cfg.timer_int_en      <= data_s[bss_pkg::D_TIMER];
      o_boot_cfg.byte_enable_n_sel <= data_s[bss_pkg::D_BYTE_EN];
      o_boot_cfg.ack_source        <= data_s[bss_pkg::D_ACK_SRC];
      o_boot_cfg.arb_select        <= data_s[bss_pkg::D_ARB];
      o_boot_cfg.boot_bus_width    <= data_s[bss_pkg::D_WIDTH_HI:0];
      // Address bits 17..15 are test-only and are never loaded
    end
  end

  // Shared pin selects: loaded at release, later writable by software
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pin_cfg <= '1;
    end else if (main_cap) begin
      o_pin_cfg.shared_pin_group_select <= addr_s[bss_pkg::A_SHARED1];
      o_pin_cfg.sel_a9                  <= addr_s[bss_pkg::A_SHARED2];
      o_pin_cfg.sel_d6                  <= data_s[bss_pkg::D_SHARED3];
      o_pin_cfg.sel_d3                  <= data_s[bss_pkg::D_SHARED4];
    end else if (pin_wr) begin
      o_pin_cfg <= i_wb_dat[3:0];
    end
  end

  // Clock-generator fields: held at the all-ones meaning while that reset is low,
  // captured on its release only; the main reset leaves them alone so that a later
  // main reset does not throw away the captured dividers
  always_ff @(posedge i_ref_clk) begin
    if (!cg_n_s) begin
      o_clk_cfg <= {bss_pkg::PCI_DIV_BASE + 4'h3, 3'h1, 2'h3, 2'h3};
      o_cg_done <= 1'b0;
    end else if (cg_rise) begin
      o_clk_cfg.pci_div_code <= addr_s[bss_pkg::A_PCI_HI:bss_pkg::A_PCI_LO];
      o_clk_cfg.pci_div      <= bss_div(bss_pkg::PCI_DIV_BASE,
                                addr_s[bss_pkg::A_PCI_HI:bss_pkg::A_PCI_LO], 1'b0);
      o_clk_cfg.sys_div_code <= addr_s[bss_pkg::A_SYS_HI:bss_pkg::A_SYS_LO];
      o_clk_cfg.sys_div      <= 3'(bss_div({1'b0, bss_pkg::SYS_DIV_BASE},
                                addr_s[bss_pkg::A_SYS_HI:bss_pkg::A_SYS_LO], 1'b1));
      o_cg_done              <= 1'b1;
    end
  end

  // Read data mux; unmapped offsets read zero
  always_comb begin
    next_rdat = 32'h0;
    case (i_wb_adr)
      bss_pkg::OFS_CHIP: begin
        next_rdat[$bits(bss_pkg::bss_boot_s)-1:0] = o_boot_cfg;
      end
      bss_pkg::OFS_PIN: begin
        next_rdat[3:0] = o_pin_cfg;
      end
      bss_pkg::OFS_CLK: begin
        next_rdat[$bits(bss_pkg::bss_clk_s)-1:0] = o_clk_cfg;
      end
      bss_pkg::OFS_STAT: begin
        next_rdat[1:0] = {o_cg_done, o_main_done};
      end
      bss_pkg::OFS_RAWA: begin
        next_rdat[bss_pkg::ADDR_W-1:0] = addr_s;
      end
      bss_pkg::OFS_RAWD: begin
        next_rdat[bss_pkg::DATA_W-1:0] = data_s;
      end
      default: begin
        next_rdat = 32'h0;
      end
    endcase
  end

  // Wishbone slave: ack one cycle after the request, dropped the cycle after
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0;
    end else begin
      o_wb_ack <= wb_req;
      if (wb_req && !i_wb_we) begin
        o_wb_dat <= next_rdat;
      end
    end
  end

  // ---------------- Assertions ----------------

  // Capture strobe followed by the done flag
  sequence s_main_cap;
    main_cap ##1 o_main_done;
  endsequence

  // Clock-generator release followed by the done flag
  sequence s_cg_cap;
    cg_rise ##1 o_cg_done;
  endsequence

  property p_main_in_time;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      !o_main_done |-> ##[1:4] o_main_done;
  endproperty
  a_main_in_time: assert property (p_main_in_time) else $error("main capture late");

  property p_role;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      s_main_cap |-> o_boot_cfg.pci_role_select == $past(addr_s[bss_pkg::A_PCI_ROLE], 1);
  endproperty
  a_role: assert property (p_role) else $error("pci role mismatch");

  property p_endian;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      s_main_cap |-> o_boot_cfg.endian_big == $past(addr_s[bss_pkg::A_ENDIAN], 1);
  endproperty
  a_endian: assert property (p_endian) else $error("endian mismatch");

  property p_shared;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      s_main_cap |-> o_pin_cfg.shared_pin_group_select == $past(addr_s[bss_pkg::A_SHARED1], 1);
  endproperty
  a_shared: assert property (p_shared) else $error("shared pin select mismatch");

  property p_width;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      s_main_cap |-> o_boot_cfg.boot_bus_width == $past(data_s[1:0], 1);
  endproperty
  a_width: assert property (p_width) else $error("boot width mismatch");

  property p_timer;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      s_main_cap |-> o_boot_cfg.timer_int_en == $past(data_s[bss_pkg::D_TIMER], 1);
  endproperty
  a_timer: assert property (p_timer) else $error("timer enable mismatch");

  property p_sys_div;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      s_cg_cap |-> o_clk_cfg.sys_div == 3'h4 - {1'b0, $past(addr_s[14:13], 1)};
  endproperty
  a_sys_div: assert property (p_sys_div) else $error("system divide wrong");

  property p_pci_div;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      s_cg_cap |-> o_clk_cfg.pci_div == 4'h8 + {2'h0, $past(addr_s[11:10], 1)};
  endproperty
  a_pci_div: assert property (p_pci_div) else $error("pci divide wrong");

  property p_hold;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      o_main_done |=> $stable(o_boot_cfg);
  endproperty
  a_hold: assert property (p_hold) else $error("boot fields changed");

  property p_clk_hold;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      o_cg_done && cg_n_s && !cg_rise |=> $stable(o_clk_cfg);
  endproperty
  a_clk_hold: assert property (p_clk_hold) else $error("clock fields changed");

  property p_ack;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      wb_req |=> o_wb_ack ##1 !o_wb_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("wishbone ack timing");

endmodule

/* File: bss_board.sv */
// Board strap resistor model feeding the address and data strap pins
`timescale 1ns/1ps
module bss_board (
  input  wire logic [bss_pkg::ADDR_W-1:0] i_pull_addr, // One marks a fitted pull-down
  input  wire logic [bss_pkg::DATA_W-1:0] i_pull_data, // One marks a fitted pull-down
  output logic      [bss_pkg::ADDR_W-1:0] o_addr_pins, // Address strap levels
  output logic      [bss_pkg::DATA_W-1:0] o_data_pins  // Data strap levels
);
  // Unpulled pins rise through the internal pull-up; test pins are never pulled
  always_comb begin
    o_addr_pins        = ~i_pull_addr;
    o_addr_pins[17:15] = 3'h7;
    o_data_pins        = ~i_pull_data;
  end
endmodule

/* File: tb_top.sv */
// Self-checking bench for the boot strap sampler
`timescale 1ns/1ps
module tb_top;
  logic                clk = 1'b0;  // Reference clock
  logic                arst_n;      // Main reset
  logic                cg_n;        // Clock-generator reset
  logic                cyc, stb, we;
  logic [4:0]          adr;
  logic [3:0]          sel;
  logic [31:0]         wdat, rdat, q;
  logic [19:0]         pull_a;      // Fitted address pull-downs
  logic [15:0]         pull_d;      // Fitted data pull-downs
  logic [19:0]         addr_pins;
  logic [15:0]         data_pins;
  logic                ack, main_done, cg_done;
  bss_pkg::bss_boot_s  boot_cfg;
  bss_pkg::bss_pins_s  pin_cfg;
  bss_pkg::bss_clk_s   clk_cfg;
  logic [10:0]         exp_clk;     // Last expected clock fields
  int                  fail_count = 0;
  int                  cmp_count = 0;

  // Clock at 200 MHz
  always #2.5 clk = ~clk;

  bss_board i_board (.i_pull_addr(pull_a), .i_pull_data(pull_d),
                     .o_addr_pins(addr_pins), .o_data_pins(data_pins));

  bss_top i_dut (.i_ref_clk(clk), .i_arst_n(arst_n), .i_clock_generator_reset_n(cg_n),
                 .i_addr_pins(addr_pins), .i_data_pins(data_pins), .i_wb_cyc(cyc),
                 .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
                 .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .o_boot_cfg(boot_cfg),
                 .o_pin_cfg(pin_cfg), .o_clk_cfg(clk_cfg), .o_main_done(main_done),
                 .o_cg_done(cg_done));

  // Pin levels expected from a pull-down mask
  function automatic logic [19:0] lvl_a(input logic [19:0] pa);
    return ~pa | 20'h38000;
  endfunction

  // Main-reset fields expected from pin levels
  function automatic logic [22:0] exp_boot(input logic [19:0] a, input logic [15:0] d);
    return {d[15:8], d[7], d[5], d[4], d[1:0], d[2], a[8:6], a[3:0], a[12], a[19]};
  endfunction

  // Shared pin selects expected from pin levels
  function automatic logic [3:0] exp_pins(input logic [19:0] a, input logic [15:0] d);
    return {d[3], d[6], a[9], a[18]};
  endfunction

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Print verdict and stop
  task automatic tally_and_finish();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // One classic Wishbone cycle, held until ack is sampled
  task automatic wb_cycle(input logic w, input logic [4:0] a, input logic [31:0] d,
                          output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    r = rdat;
    if (n >= 50) check(32'h0, 32'h1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  // Main reset with a strap pattern, then check capture
  task automatic main_reset(input logic [19:0] pa, input logic [15:0] pd);
    int n;
    @(posedge clk);
    arst_n <= 1'b0;
    pull_a <= pa;
    pull_d <= pd;
    repeat (3) @(posedge clk);
    check({9'h0, boot_cfg}, 32'h7fffff);
    check({28'h0, pin_cfg}, 32'hf);
    check({31'h0, main_done}, 32'h0);
    arst_n <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (main_done !== 1'b1 && n < 20);
    check(n, 4);
    @(posedge clk);
    check({9'h0, boot_cfg}, {9'h0, exp_boot(lvl_a(pa), ~pd)});
    check({28'h0, pin_cfg}, {28'h0, exp_pins(lvl_a(pa), ~pd)});
  endtask

  // Clock-generator reset with divider codes
  task automatic cg_reset(input logic [1:0] pc, input logic [1:0] sc);
    @(posedge clk);
    cg_n <= 1'b0;
    pull_a[11:10] <= ~pc;
    pull_a[14:13] <= ~sc;
    repeat (3) @(posedge clk);
    cg_n <= 1'b1;
    repeat (4) @(posedge clk);
    exp_clk = {4'h8 + {2'h0, pc}, 3'h4 - {1'h0, sc}, pc, sc};
    check({21'h0, clk_cfg}, {21'h0, exp_clk});
    check({31'h0, cg_done}, 32'h1);
  endtask

  // Watchdog
  initial begin
    #20000;
    fail_count++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    arst_n = 1'b1;
    cg_n = 1'b0;
    {cyc, stb, we} = 3'h0;
    adr = 5'h00;
    sel = 4'h0;
    wdat = 32'h0;
    pull_a = 20'h0;
    pull_d = 16'h0;
    // A real falling edge so every flop on i_arst_n sees the asynchronous reset
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (10) @(posedge clk);
    main_reset(20'h00000, 16'h0000);
    main_reset(20'hfffff, 16'hffff);
    main_reset(20'h5a5a5, 16'ha5c3);
    for (int c = 0; c < 4; c++) begin
      cg_reset(c[1:0], 2'(3 - c));
    end
    // Captured fields ignore later strap changes
    pull_a <= 20'h0;
    pull_d <= 16'h0;
    repeat (5) @(posedge clk);
    check({9'h0, boot_cfg}, {9'h0, exp_boot(lvl_a(20'h5a5a5), ~16'ha5c3)});
    check({28'h0, pin_cfg}, {28'h0, exp_pins(lvl_a(20'h5a5a5), ~16'ha5c3)});
    // Register access, read-only and unmapped places
    wb_cycle(1'b1, 5'h00, 32'hffffffff, q);
    wb_cycle(1'b0, 5'h00, 32'h0, q);
    check(q, {9'h0, exp_boot(lvl_a(20'h5a5a5), ~16'ha5c3)});
    wb_cycle(1'b0, 5'h08, 32'h0, q);
    check(q, {21'h0, exp_clk});
    wb_cycle(1'b0, 5'h0c, 32'h0, q);
    check(q, 32'h3);
    wb_cycle(1'b1, 5'h18, 32'h5a5a5a5a, q);
    wb_cycle(1'b0, 5'h18, 32'h0, q);
    check(q, 32'h0);
    wb_cycle(1'b0, 5'h10, 32'h0, q);
    check(q, {12'h0, lvl_a(20'h0)});
    wb_cycle(1'b1, 5'h04, 32'h00000005, q);
    check({28'h0, pin_cfg}, 32'h5);
    wb_cycle(1'b0, 5'h04, 32'h0, q);
    check(q, 32'h5);
    // A fresh main reset recaptures the shared pin selects
    main_reset(20'h5a5a5, 16'ha5c3);
    check({21'h0, clk_cfg}, {21'h0, exp_clk});
    tally_and_finish();
  end
endmodule
